//--- fss_params.svh
// Timing counts and widths for the fan start-up and fault supervisor
`ifndef FSS_PARAMS_SVH
`define FSS_PARAMS_SVH

`define FSS_CLK_MHZ 100
`define FSS_PWM_STEPS 256
`define FSS_DUTY_W 8
`define FSS_DUTY_FULL 8'hFF
`define FSS_STARTUP_CYC 32
`define FSS_MISSING_CYC 32
`define FSS_DIAG_CYC 3
`define FSS_STARTUP_TRIES 2
`define FSS_BLANK_STEPS 4
`define FSS_CNT_W 6

`endif

//--- fss_pkg.sv
// Types shared by the fan start-up and fault supervisor
package fss_pkg;
    typedef enum logic [2:0] {
        FSS_SHUTDOWN,
        FSS_STARTUP,
        FSS_NORMAL,
        FSS_DIAG,
        FSS_RETRY,
        FSS_FAN_FAULT
    } fss_state_t;
endpackage : fss_pkg

//--- fss_pwm_gen.sv
// PWM period timebase and duty comparator
`timescale 1ns/1ns
`include "fss_params.svh"
module fss_pwm_gen
    import fss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic run_i,
    input wire logic [`FSS_DUTY_W-1:0] duty_i,
    output logic pwm_o,
    output logic period_end_o,
    output logic [`FSS_DUTY_W-1:0] phase_o
);
    logic [`FSS_DUTY_W-1:0] duty_r;

    // Phase runs freely so the timebase keeps ticking in every state
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_o <= 8'h00;
        end else if (en_i) begin
            phase_o <= phase_o + 8'h01;
        end
    end

    // Duty latched at period start so a cycle is never cut mid-way
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            duty_r <= 8'h00;
        end else if (en_i && phase_o == `FSS_DUTY_FULL) begin
            duty_r <= duty_i;
        end
    end

    always_comb begin
        period_end_o = (phase_o == `FSS_DUTY_FULL);
        // Full duty means on for the whole period
        pwm_o = run_i && ((duty_r == `FSS_DUTY_FULL) || (phase_o < duty_r));
    end
endmodule : fss_pwm_gen

//--- fss_supervisor.sv
// Fan start-up, missing-pulse diagnosis and fault supervisor
// Notes on behaviour
// - Start from off holds drive on until a pulse, at most 32 PWM cycles per try
// - Shutdown suspends all; resume only after release seen
// - Shutdown request always returns all sequencing state to reset
// - Fault output inactive (high) in shutdown
// - Drive held off in shutdown even at full temperature request
// - Sense pulses near drive turn-on are blanked, not counted
// - 32 PWM cycles without pulse starts diagnostic timer
// - Diagnostic: drive on continuously three cycles, watch for pulse
// - No pulse in diagnostic starts start-up timer; pulse returns normal
// - Timeout after retry stops PWM, fault low, latched off
// - Fan fault left only by shutdown then release, restarts power-up
// - In fan fault, fault output low and drive disabled
// - Normal: fault asserted while over-temperature input is high
// - Over-temperature keeps fan running, no self shutdown
// - Normal duty is the larger of the two requests
// - Each pulse restarts normal loop, clearing missing-pulse count
// - Power-up start-up runs twice without pulse before fan fault
// - Shutdown in normal: zero duty, fault off, resume as power-up
// - PWM period is the single timebase for all timers
`timescale 1ns/1ns
`include "fss_params.svh"
module fss_supervisor
    import fss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic fan_sense_i,
    input wire logic shutdown_req_i,
    input wire logic release_i,
    input wire logic overtemp_i,
    input wire logic [`FSS_DUTY_W-1:0] temp_duty_request_i,
    input wire logic [`FSS_DUTY_W-1:0] min_speed_request_i,
    output logic fan_drive_out_o,
    output logic fault_n_o,
    output logic fan_fault_o,
    output logic shutdown_o
);
    fss_state_t state_r;
    fss_state_t state_nxt;
    logic [`FSS_CNT_W-1:0] cnt_r;
    logic [1:0] tries_r;
    logic [1:0] sense_sync_r;
    logic sense_d_r;
    logic [1:0] shdn_sync_r;
    logic [1:0] rel_sync_r;
    logic [1:0] ot_sync_r;
    logic [`FSS_DUTY_W-1:0] duty_max;
    logic [`FSS_DUTY_W-1:0] duty_sel;
    logic pwm_raw;
    logic period_end;
    logic [`FSS_DUTY_W-1:0] phase;
    logic run;
    logic force_on;
    logic blank;
    logic pulse;
    logic shdn;

    function automatic logic [`FSS_DUTY_W-1:0] max_duty(
        input logic [`FSS_DUTY_W-1:0] a,
        input logic [`FSS_DUTY_W-1:0] b
    );
        max_duty = (a > b) ? a : b;
    endfunction : max_duty

    // Level inputs come from the analog front end already hysteretic
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sense_sync_r <= 2'h0;
            sense_d_r <= 1'b0;
            shdn_sync_r <= 2'h3;
            rel_sync_r <= 2'h0;
            ot_sync_r <= 2'h0;
        end else if (en_i) begin
            sense_sync_r <= {sense_sync_r[0], fan_sense_i};
            sense_d_r <= sense_sync_r[1];
            shdn_sync_r <= {shdn_sync_r[0], shutdown_req_i};
            rel_sync_r <= {rel_sync_r[0], release_i};
            ot_sync_r <= {ot_sync_r[0], overtemp_i};
        end
    end

    assign shdn = shdn_sync_r[1];
    // Turn-on edge disturbs the sense line; mask a few steps after it
    assign blank = (phase < `FSS_DUTY_W'(`FSS_BLANK_STEPS));
    assign pulse = sense_sync_r[1] && !sense_d_r && !blank;

    assign duty_max = max_duty(temp_duty_request_i, min_speed_request_i);
    // States that hold the drive on for the whole PWM period
    function automatic logic is_forced(input fss_state_t s);
        is_forced = (s == FSS_STARTUP) || (s == FSS_RETRY) || (s == FSS_DIAG);
    endfunction : is_forced

    function automatic logic is_running(input fss_state_t s);
        is_running = (s != FSS_SHUTDOWN) && (s != FSS_FAN_FAULT);
    endfunction : is_running

    assign force_on = is_forced(state_r);
    assign run = is_running(state_r);
    assign duty_sel = force_on ? `FSS_DUTY_FULL : duty_max;

    fss_pwm_gen u_pwm (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .en_i(en_i),
        .run_i(run),
        .duty_i(duty_sel),
        .pwm_o(pwm_raw),
        .period_end_o(period_end),
        .phase_o(phase)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FSS_SHUTDOWN: begin
                if (!shdn && rel_sync_r[1]) begin
                    state_nxt = FSS_STARTUP;
                end
            end
            FSS_STARTUP: begin
                if (pulse) begin
                    state_nxt = FSS_NORMAL;
                end else if (period_end && cnt_r == `FSS_CNT_W'(`FSS_STARTUP_CYC - 1)
                             && tries_r == 2'(`FSS_STARTUP_TRIES - 1)) begin
                    state_nxt = FSS_FAN_FAULT;
                end
            end
            FSS_NORMAL: begin
                if (period_end && cnt_r == `FSS_CNT_W'(`FSS_MISSING_CYC - 1) && !pulse) begin
                    state_nxt = FSS_DIAG;
                end
            end
            FSS_DIAG: begin
                if (pulse) begin
                    state_nxt = FSS_NORMAL;
                end else if (period_end && cnt_r == `FSS_CNT_W'(`FSS_DIAG_CYC - 1)) begin
                    state_nxt = FSS_RETRY;
                end
            end
            FSS_RETRY: begin
                if (pulse) begin
                    state_nxt = FSS_NORMAL;
                end else if (period_end && cnt_r == `FSS_CNT_W'(`FSS_STARTUP_CYC - 1)) begin
                    state_nxt = FSS_FAN_FAULT;
                end
            end
            FSS_FAN_FAULT: begin
                state_nxt = FSS_FAN_FAULT;
            end
            default: begin
                state_nxt = FSS_SHUTDOWN;
            end
        endcase
        // Shutdown overrides every state, fault included
        if (shdn) begin
            state_nxt = FSS_SHUTDOWN;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= FSS_SHUTDOWN;
        end else if (en_i) begin
            state_r <= state_nxt;
        end
    end

    // All timers count PWM periods; a state change restarts the count
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 6'h00;
            tries_r <= 2'h0;
        end else if (en_i) begin
            if (state_nxt != state_r || pulse || shdn) begin
                cnt_r <= 6'h00;
                if (state_nxt != FSS_STARTUP || shdn) begin
                    tries_r <= 2'h0;
                end
            end else if (period_end) begin
                if (state_r == FSS_STARTUP
                    && cnt_r == `FSS_CNT_W'(`FSS_STARTUP_CYC - 1)) begin
                    cnt_r <= 6'h00;
                    tries_r <= tries_r + 2'h1;
                end else begin
                    cnt_r <= cnt_r + 6'h01;
                end
            end
        end
    end

    // Over-temperature only flags; the fan keeps running
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fan_drive_out_o <= 1'b0;
            fault_n_o <= 1'b1;
            fan_fault_o <= 1'b0;
            shutdown_o <= 1'b1;
        end else if (en_i) begin
            // Decoded from the next state so the kick starts with no gap and stops with the fault
            fan_drive_out_o <= is_running(state_nxt)
                               && (is_forced(state_nxt) || pwm_raw);
            if (state_nxt == FSS_FAN_FAULT) begin
                fault_n_o <= 1'b0;
            end else if (state_nxt == FSS_SHUTDOWN) begin
                fault_n_o <= 1'b1;
            end else begin
                fault_n_o <= !ot_sync_r[1];
            end
            fan_fault_o <= (state_nxt == FSS_FAN_FAULT);
            shutdown_o <= (state_nxt == FSS_SHUTDOWN) || (state_nxt == FSS_FAN_FAULT);
        end
    end
endmodule : fss_supervisor

//--- fss_fan_model.sv
// Behavioural fan that gives commutation pulses while energised
`timescale 1ns/1ns
module fss_fan_model (
    input wire logic clk_i,
    input wire logic alive_i,
    input wire logic drive_i,
    output logic sense_o
);
    logic [4:0] on_cnt_r;
    // A stalled fan stays silent; a running one pulses only while driven, clear of turn-on
    always_ff @(posedge clk_i) begin
        on_cnt_r <= drive_i ? on_cnt_r + 5'h01 : 5'h00;
        sense_o <= alive_i && drive_i && (on_cnt_r == 5'h10);
    end
endmodule : fss_fan_model

//--- fss_supervisor_assertions.sv
// Port checks for the fan supervisor
`timescale 1ns/1ns
module fss_sup_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic shutdown_req_i,
    input wire logic overtemp_i,
    input wire logic fan_drive_out_o,
    input wire logic fault_n_o,
    input wire logic fan_fault_o,
    input wire logic shutdown_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    drive_shut_a: assert property (shutdown_o && $past(shutdown_o) |-> !fan_drive_out_o)
        else $error("drive on in shutdown");
    fault_idle_a: assert property (shutdown_o && !fan_fault_o |-> fault_n_o)
        else $error("fault active in shutdown");
    fan_fault_a: assert property (fan_fault_o |-> !fault_n_o && !fan_drive_out_o && shutdown_o)
        else $error("fan fault outputs wrong");
    fault_hold_a: assert property (fan_fault_o && !shutdown_req_i && !$past(shutdown_req_i)
        && !$past(shutdown_req_i, 2) && !$past(shutdown_req_i, 3) |=> fan_fault_o)
        else $error("fan fault left without shutdown");
    shut_req_a: assert property (shutdown_req_i [*6] |-> shutdown_o && fault_n_o)
        else $error("shutdown request not obeyed");
    self_shut_a: assert property ($rose(shutdown_o) |-> fan_fault_o || $past(shutdown_req_i, 2)
        || $past(shutdown_req_i, 3) || $past(shutdown_req_i, 4))
        else $error("shutdown without cause");
    ot_flag_a: assert property ((overtemp_i && !shutdown_o) [*6] |-> !fault_n_o)
        else $error("overtemp not flagged");
    ot_clear_a: assert property ((!overtemp_i && !fan_fault_o) [*6] |-> fault_n_o)
        else $error("fault stuck after overtemp");
    start_on_a: assert property ($fell(shutdown_o) |=> fan_drive_out_o [*8])
        else $error("start-up kick missing");
endmodule : fss_sup_chk

bind fss_supervisor fss_sup_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .shutdown_req_i(shutdown_req_i), .overtemp_i(overtemp_i), .fan_drive_out_o(fan_drive_out_o),
    .fault_n_o(fault_n_o), .fan_fault_o(fan_fault_o), .shutdown_o(shutdown_o));

//--- fss_tb.sv
// Self-checking bench for the fan supervisor
`timescale 1ns/1ns
`include "fss_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    localparam int P = `FSS_PWM_STEPS;
    logic clk_i = 1'b0, rstn_i = 1'b0, en_i = 1'b1, fan_sense_i, alive = 1'b0;
    logic shutdown_req_i = 1'b0, release_i = 1'b1, overtemp_i = 1'b0;
    logic [`FSS_DUTY_W-1:0] temp_r = 8'h00, min_r = 8'h00;
    logic fan_drive_out_o, fault_n_o, fan_fault_o, shutdown_o;
    logic [8:0] a, b;
    int checks = 0, err_count = 0, cyc = 0;
    fss_supervisor DUT (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .fan_sense_i(fan_sense_i),
        .shutdown_req_i(shutdown_req_i), .release_i(release_i), .overtemp_i(overtemp_i),
        .temp_duty_request_i(temp_r), .min_speed_request_i(min_r),
        .fan_drive_out_o(fan_drive_out_o), .fault_n_o(fault_n_o), .fan_fault_o(fan_fault_o),
        .shutdown_o(shutdown_o));
    fss_fan_model u_fan (.clk_i(clk_i), .alive_i(alive), .drive_i(fan_drive_out_o),
        .sense_o(fan_sense_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wt
    task automatic meas(output logic [8:0] n);
        n = 9'h000;
        repeat (P) begin
            @(negedge clk_i);
            n = n + {8'h00, fan_drive_out_o};
        end
    endtask : meas
    task automatic t_dead;
        wt(10 * P);
        `CHK(fan_drive_out_o, 1'b1)
        wt(50 * P);
        `CHK(fan_drive_out_o, 1'b1)
        wt(5 * P);
        `CHK(fan_fault_o, 1'b1)
        `CHK(fault_n_o, 1'b0)
        $display("dead fan test done");
    endtask : t_dead
    task automatic t_restart;
        temp_r = 8'hFF;
        shutdown_req_i = 1'b1;
        wt(10);
        `CHK(shutdown_o, 1'b1)
        `CHK(fault_n_o, 1'b1)
        `CHK(fan_drive_out_o, 1'b0)
        release_i = 1'b0;
        shutdown_req_i = 1'b0;
        wt(10);
        `CHK(shutdown_o, 1'b1)
        alive = 1'b1;
        temp_r = 8'h40;
        min_r = 8'h80;
        release_i = 1'b1;
        wt(10);
        `CHK(fan_fault_o, 1'b0)
        `CHK(fan_drive_out_o, 1'b1)
        $display("restart test done");
    endtask : t_restart
    task automatic t_normal;
        wt(4 * P);
        meas(a);
        temp_r = 8'h80;
        min_r = 8'h40;
        wt(2 * P);
        meas(b);
        `CHK(a, b)
        `CHK(a >= 9'h07F && a <= 9'h081, 1'b1)
        overtemp_i = 1'b1;
        wt(10);
        `CHK(fault_n_o, 1'b0)
        meas(a);
        `CHK(a, b)
        overtemp_i = 1'b0;
        wt(10);
        `CHK(fault_n_o, 1'b1)
        $display("normal test done");
    endtask : t_normal
    task automatic t_stall;
        alive = 1'b0;
        wt(29 * P);
        meas(a);
        `CHK(a, b)
        wt(6 * P);
        meas(a);
        `CHK(a, 9'h100)
        wt(24 * P);
        `CHK(fan_fault_o, 1'b0)
        wt(10 * P);
        `CHK(fan_fault_o, 1'b1)
        `CHK(fault_n_o, 1'b0)
        $display("stall test done");
    endtask : t_stall
    task end_sim;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Hang guard sized well above the roughly 40000 cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        wt(20);
        rstn_i = 1'b1;
        t_dead();
        t_restart();
        t_normal();
        t_stall();
        end_sim();
    end
endmodule : testbench
